/* dv/act_seq_sva.sv */
// checker for the converter timing sequencer, bound to act_seq
// assumes clk_en stays high, so every cycle counts
`timescale 1ns/100ps

module act_seq_sva (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        start,
  input wire logic [15:0] converter_control_word,
  input wire logic [9:0]  ain_level,
  input wire logic        ain_under,
  input wire logic        ain_over,
  input wire logic        busy,
  input wire logic        sampling,
  input wire logic        done,
  input wire logic [9:0]  result
);
  logic [11:0] cnt_ff;
  logic [7:0]  cc_ff;
  logic [4:0]  sc_ff;
  logic        hu_ff;
  logic        ho_ff;
  logic [9:0]  hl_ff;
  // cycles since the start edge, plus one; periods latched there
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_ff <= 12'h000;
    end else if (clk_en && start && !busy) begin
      cnt_ff <= 12'h001;
      cc_ff  <= (converter_control_word[15:14] == 2'h2) ? 8'h30 :
                (converter_control_word[15:14] == 2'h3) ? 8'h18 : 8'h0C;
      sc_ff  <= 5'h02 << converter_control_word[13:12];
    end else if (clk_en && busy) begin
      cnt_ff <= cnt_ff + 12'h001;
    end
  end
  // last input seen while sampling is what the result must reflect
  always_ff @(posedge sys_clk) begin
    if (sampling) begin
      hu_ff <= ain_under;
      ho_ff <= ain_over;
      hl_ff <= ain_level;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
  a_done_ends_busy: assert property (done |-> !busy && $past(busy)) else $error("done without busy end");
  a_start_taken: assert property (clk_en && start && !busy |=> busy && sampling) else $error("start not taken");
  a_sample_len: assert property ($fell(sampling) |-> cnt_ff == sc_ff * cc_ff + 12'h001) else $error("sample length wrong");
  a_conv_len: assert property ($rose(done) |-> cnt_ff == (sc_ff + 5'h0E) * cc_ff + 12'h003) else $error("conversion length wrong");
  a_under_zero: assert property (done && hu_ff |-> result == 10'h000) else $error("under not zero");
  a_over_full: assert property (done && !hu_ff && ho_ff |-> result == 10'h3FF) else $error("over not full");
  a_result_held: assert property (done && !hu_ff && !ho_ff |-> result == hl_ff) else $error("result not held level");
  a_result_stable: assert property (!done |-> $stable(result)) else $error("result moved without done");
endmodule

bind act_seq act_seq_sva u_act_seq_sva (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
  .start(start), .converter_control_word(converter_control_word), .ain_level(ain_level),
  .ain_under(ain_under), .ain_over(ain_over), .busy(busy), .sampling(sampling), .done(done),
  .result(result));

/* dv/tb.sv */
// self-checking bench for act_seq: corner and random conversions
// assumes a 10 MHz clock and clk_en held high
`timescale 1ns/100ps

module tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        start = 1'b0;
  logic [15:0] converter_control_word = 16'h0000;
  logic [9:0]  ain_level = 10'h000;
  logic        ain_under = 1'b0;
  logic        ain_over = 1'b0;
  logic        busy;
  logic        sampling;
  logic        done;
  logic [9:0]  result;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          i;

  always #50 sys_clk = ~sys_clk;

  act_seq u_act_seq (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .start(start),
    .converter_control_word(converter_control_word), .ain_level(ain_level),
    .ain_under(ain_under), .ain_over(ain_over), .busy(busy), .sampling(sampling),
    .done(done), .result(result));

  task automatic results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_res(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t result %h expected %h", $time, got, exp);
    end
  endtask

  // reserved code 01 runs like 00
  function automatic int exp_c(input logic [1:0] c);
    return (c == 2'h2) ? 48 : (c == 2'h3) ? 24 : 12;
  endfunction

  function automatic logic [9:0] exp_r(input logic [9:0] l, input logic u, input logic o);
    return u ? 10'h000 : (o ? 10'h3FF : l);
  endfunction

  // a second start and a new control word mid-run must be ignored;
  // inputs flip once sampling ends to prove the held value is used
  task automatic conv(input logic [15:0] cw, input logic [9:0] l, input logic u, input logic o);
    int n;
    int sn;
    int c;
    int s;
    c = exp_c(cw[15:14]);
    s = 2 << cw[13:12];
    start = 1'b1;
    converter_control_word = cw;
    ain_level = l;
    ain_under = u;
    ain_over = o;
    @(negedge sys_clk);
    start = 1'b0;
    n = 0;
    sn = 0;
    while (done !== 1'b1 && n < 3000) begin
      if (sampling !== 1'b1 && sn == 0) sn = n;
      if (sn != 0) begin
        ain_level = ~l;
        ain_under = ~u;
        ain_over = ~o;
      end
      start = (n == 5);
      if (n == 5) converter_control_word = ~cw;
      @(negedge sys_clk);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      $display("ERROR %0t no done", $time);
      results();
    end
    chk_cnt(sn, s * c);
    chk_cnt(n, (s + 14) * c + 2);
    chk_res(result, exp_r(l, u, o));
    chk_cnt({31'h0, busy}, 32'h0);
  endtask

  initial begin
    void'($urandom(32'hD2A4));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    chk_res(result, 10'h000);
    for (i = 0; i < 4; i++) conv({i[1:0], i[1:0], 12'h000}, 10'($urandom), 1'b0, 1'b0);
    conv(16'hB000, 10'h3FF, 1'b0, 1'b0);
    conv(16'h0000, 10'h155, 1'b1, 1'b1);
    conv(16'h1000, 10'h2AA, 1'b0, 1'b1);
    for (i = 0; i < 12; i++) conv(16'($urandom), 10'($urandom), ($urandom % 4) == 0,
      ($urandom % 4) == 0);
    results();
  end
endmodule

/* src/act_map.svh */
// constants of the converter timing sequencer: field positions, counts, reset values
// assumes inclusion by bare name from every file that needs them
`ifndef ACT_MAP_SVH
`define ACT_MAP_SVH

`define ACT_CC_SEL_HI       15
`define ACT_CC_SEL_LO       14
`define ACT_SC_SEL_HI       13
`define ACT_SC_SEL_LO       12
`define ACT_HP_CC_CODE00    8'h18
`define ACT_HP_CC_CODE10    8'h60
`define ACT_HP_CC_CODE11    8'h30
`define ACT_HP_PER_CYCLE    8'h02
`define ACT_SAMPLE_SC_COUNT 5'h02
`define ACT_CONV_CC_COUNT   5'h0E
`define ACT_SAR_BITS        5'h0A
`define ACT_FINISH_HP       3'h4
`define ACT_RESULT_ZERO     10'h000
`define ACT_RESULT_FULL     10'h3FF
`define ACT_SAR_TOP_BIT     10'h200

`endif

/* src/act_pkg.sv */
// types shared by the converter timing sequencer
// assumes act_map.svh supplies the numeric constants
package act_pkg;
  typedef enum logic [1:0] {
    ACT_IDLE,
    ACT_SAMPLE,
    ACT_CONVERT,
    ACT_FINISH
  } act_state_t;
endpackage

/* src/act_seq.sv */
// converter timing sequencer: sample phase, successive approximation, result load
// assumes start and the analog front-end levels come from logic on sys_clk
// assumes clk_en gates every state change, so all counts are in enabled cycles
// What this block does
// RULE1 - the conversion clock select gives 24, 96 or 48 cpu half-periods for codes 00, 10, 11.
// RULE2 - the sample clock select in control bits 13:12 gives 1, 2, 4 or 8 conversion clocks.
// RULE3 - sampling lasts exactly two sample clock periods, no more and no less.
// RULE4 - a conversion takes 14 conversion clocks plus sampling plus 4 cpu half-periods.
// RULE5 - after sampling the input is held, so later input changes cannot alter the result.
// RULE6 - an input below ground gives result 000 and one above the reference gives 3FF.
// RULE7 - timing counts cpu half-periods, the time between consecutive clock edges.
// RULE8 - start begins sampling then conversion, busy holds until load, then done pulses once.
`timescale 1ns/100ps
`include "act_map.svh"

module act_seq (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic [15:0] converter_control_word,
  input  wire logic [9:0]  ain_level,
  input  wire logic        ain_under,
  input  wire logic        ain_over,
  output logic             busy,
  output logic             sampling,
  output logic             done,
  output logic [9:0]       result
);
  act_pkg::act_state_t state_ff;
  logic [1:0]  cc_sel_ff;
  logic [1:0]  sc_sel_ff;
  logic [7:0]  cc_period_hp;
  logic [4:0]  sample_len;
  logic [4:0]  phase_cnt_ff;
  logic [2:0]  fin_hp_ff;
  logic [9:0]  held_ff;
  logic        held_under_ff;
  logic        held_over_ff;
  logic [9:0]  sar_ff;
  logic [9:0]  trial_bit_ff;
  logic [9:0]  result_ff;
  logic        busy_ff;
  logic        sampling_ff;
  logic        done_ff;
  logic        cc_tick;
  logic        take_start;
  logic        sample_end;
  logic        convert_end;
  logic        finish_end;

  // the reserved code 01 is treated like 00; software must not rely on it
  always_comb begin
    unique case (cc_sel_ff)
      2'h2:    cc_period_hp = `ACT_HP_CC_CODE10; // [RULE1]
      2'h3:    cc_period_hp = `ACT_HP_CC_CODE11; // [RULE1]
      default: cc_period_hp = `ACT_HP_CC_CODE00; // [RULE1]
    endcase
  end

  // two sample clocks, each 1, 2, 4 or 8 conversion clocks long
  assign sample_len = `ACT_SAMPLE_SC_COUNT << sc_sel_ff; // [RULE2] [RULE3]

  act_tick u_tick (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .run       (busy_ff),
    .period_hp (cc_period_hp),
    .tick      (cc_tick)
  );

  // a start while busy is dropped silently; nothing queues it for later
  assign take_start  = (state_ff == act_pkg::ACT_IDLE) && start; // [RULE8]
  assign sample_end  = (state_ff == act_pkg::ACT_SAMPLE) && cc_tick &&
                       (phase_cnt_ff == sample_len - 5'h01); // [RULE3]
  assign convert_end = (state_ff == act_pkg::ACT_CONVERT) && cc_tick &&
                       (phase_cnt_ff == `ACT_CONV_CC_COUNT - 5'h01); // [RULE4]
  assign finish_end  = (state_ff == act_pkg::ACT_FINISH) &&
                       (fin_hp_ff + 3'(`ACT_HP_PER_CYCLE) >= `ACT_FINISH_HP); // [RULE4] [RULE7]

  // finish is left on the load edge, so a start may be taken while done is high
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= act_pkg::ACT_IDLE;
    end else if (clk_en) begin
      unique case (state_ff)
        act_pkg::ACT_IDLE:    if (take_start)  state_ff <= act_pkg::ACT_SAMPLE;
        act_pkg::ACT_SAMPLE:  if (sample_end)  state_ff <= act_pkg::ACT_CONVERT;
        act_pkg::ACT_CONVERT: if (convert_end) state_ff <= act_pkg::ACT_FINISH;
        act_pkg::ACT_FINISH:  if (finish_end)  state_ff <= act_pkg::ACT_IDLE;
      endcase
    end
  end

  // selects are captured at start so a rewrite mid-conversion cannot bend the timing
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cc_sel_ff <= 2'h0;
      sc_sel_ff <= 2'h0;
    end else if (clk_en && take_start) begin
      cc_sel_ff <= converter_control_word[`ACT_CC_SEL_HI:`ACT_CC_SEL_LO]; // [RULE1]
      sc_sel_ff <= converter_control_word[`ACT_SC_SEL_HI:`ACT_SC_SEL_LO]; // [RULE2]
    end
  end

  // conversion clock ticks counted within a phase; the tick generator is preloaded
  // so its first tick lands exactly one period after the start edge, which keeps
  // every phase boundary on a whole number of conversion clocks
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_cnt_ff <= 5'h00;
    end else if (clk_en) begin
      if (take_start || sample_end || convert_end) begin
        phase_cnt_ff <= 5'h00;
      end else if (cc_tick) begin
        phase_cnt_ff <= phase_cnt_ff + 5'h01;
      end
    end
  end

  // the four half-periods of the load phase are two enabled cycles
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fin_hp_ff <= 3'h0;
    end else if (clk_en) begin
      if (state_ff == act_pkg::ACT_FINISH) begin
        fin_hp_ff <= fin_hp_ff + 3'(`ACT_HP_PER_CYCLE); // [RULE7]
      end else begin
        fin_hp_ff <= 3'h0;
      end
    end
  end

  // the input tracks freely while sampling and freezes on its last edge
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      held_ff       <= `ACT_RESULT_ZERO;
      held_under_ff <= 1'b0;
      held_over_ff  <= 1'b0;
    end else if (clk_en && (state_ff == act_pkg::ACT_SAMPLE)) begin
      held_ff       <= ain_level; // [RULE5]
      held_under_ff <= ain_under; // [RULE5]
      held_over_ff  <= ain_over;  // [RULE5]
    end
  end

  // one result bit per conversion clock, msb first, over the first ten of fourteen
  // the last four ticks carry no bit; they only pad the conversion to its fixed length
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sar_ff       <= `ACT_RESULT_ZERO;
      trial_bit_ff <= `ACT_SAR_TOP_BIT;
    end else if (clk_en) begin
      if (sample_end) begin
        sar_ff       <= `ACT_RESULT_ZERO;
        trial_bit_ff <= `ACT_SAR_TOP_BIT;
      end else if ((state_ff == act_pkg::ACT_CONVERT) && cc_tick &&
                   (phase_cnt_ff < `ACT_SAR_BITS)) begin
        if (held_ff >= (sar_ff | trial_bit_ff)) begin
          sar_ff <= sar_ff | trial_bit_ff; // [RULE4]
        end
        trial_bit_ff <= trial_bit_ff >> 1;
      end
    end
  end

  // under wins when both range flags are held, so the load is never ambiguous
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      result_ff <= `ACT_RESULT_ZERO;
    end else if (clk_en && finish_end) begin
      if (held_under_ff) begin
        result_ff <= `ACT_RESULT_ZERO; // [RULE6]
      end else if (held_over_ff) begin
        result_ff <= `ACT_RESULT_FULL; // [RULE6]
      end else begin
        result_ff <= sar_ff; // [RULE4]
      end
    end
  end

  // busy also runs the tick generator, so it must rise on the very start edge
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
    end else if (clk_en) begin
      if (take_start) begin
        busy_ff <= 1'b1; // [RULE8]
      end else if (finish_end) begin
        busy_ff <= 1'b0; // [RULE8]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sampling_ff <= 1'b0;
    end else if (clk_en) begin
      if (take_start) begin
        sampling_ff <= 1'b1; // [RULE3]
      end else if (sample_end) begin
        sampling_ff <= 1'b0; // [RULE3]
      end
    end
  end

  // done and the result register change on the same edge
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      done_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= finish_end; // [RULE8]
    end
  end

  assign busy     = busy_ff;
  assign sampling = sampling_ff;
  assign done     = done_ff;
  assign result   = result_ff;
endmodule

/* src/act_tick.sv */
// conversion clock generator: one pulse per programmed number of cpu half-periods
// assumes period_hp is even and at least four, and steady while run is high
`timescale 1ns/100ps
`include "act_map.svh"

module act_tick (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [7:0] period_hp,
  output logic            tick
);
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic       tick_ff;

  // two clock edges pass in every sys_clk cycle, so the count moves by two half-periods
  assign nxt_count = count_ff + `ACT_HP_PER_CYCLE; // [RULE7]

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count_ff <= `ACT_HP_PER_CYCLE;
      tick_ff  <= 1'b0;
    end else if (clk_en) begin
      // preload counts the start edge itself, else the registered tick lands one cycle late
      if (!run) begin
        count_ff <= `ACT_HP_PER_CYCLE; // [RULE7]
        tick_ff  <= 1'b0;
      end else if (nxt_count >= period_hp) begin
        count_ff <= 8'h00;
        tick_ff  <= 1'b1;
      end else begin
        count_ff <= nxt_count;
        tick_ff  <= 1'b0;
      end
    end
  end

  assign tick = tick_ff;
endmodule
